// ===== cpg_carrier.v
// Carrier generator mode timer with gated carrier output
//
// Overview of operation
// - High compare reload needs three count clocks
// - Counter stopped while carrier timer enable low
// - Enable starts count, carrier held inactive
// - First comparison uses low-width value
// - Low match: irq, invert, clear, select high
// - High match: irq, invert, clear, select low
// - Equal compares give 50% duty
// - Gating irq synchronised to count clock
// - Transfer pulse copies gate buffer to active
// - Gate low, carrier low: output low
// - Pulses start at carrier rising edge only
// - High pulse kept full width on gate drop
// - High compare write latched until old match while running
// - Next high match uses newly written value
// - Output table of remote enable and gate
// - Transfer lands second count clock after pulse
//
// Design decisions made here: the strobed register port and the address map.
`include "cpg_consts.vh"
module cpg_carrier #(
  parameter W     = `CPG_W,
  parameter PRE_W = `CPG_PRE_W
) (
  input  wire                  mclk_i,                  // 50 MHz system clock
  input  wire                  nrst_i,                  // Async reset, active low
  input  wire [`CPG_ADDR_W-1:0] addr_i,                 // Register address
  input  wire [W-1:0]          wdata_i,                 // Write data
  input  wire                  wr_i,                    // Write strobe
  input  wire                  rd_i,                    // Read strobe
  output reg  [W-1:0]          rdata_o,                 // Read data, cycle after strobe
  input  wire                  gating_timer_match_irq_i, // Gating timer match, async
  input  wire                  gating_timer_enable_i,   // Gating timer running, async
  output reg                   carrier_match_irq_o,     // One-cycle match pulse
  output reg                   carrier_out_pin_o        // Carrier output pin
);
  // ************************************************************
  // Registers
  // ************************************************************
  reg [W-1:0]            low_width_compare;
  reg [W-1:0]            high_width_compare;       // Active high compare
  reg [W-1:0]            high_width_latch;         // Software written value
  reg                    high_pending;
  reg [1:0]              load_age;                 // Count clocks since write
  reg                    carrier_timer_enable;
  reg [`CPG_CKS_W-1:0]   count_clock_select;
  reg                    carrier_gate_buffer;
  reg                    carrier_gate_active;
  reg                    remote_output_enable;
  reg [W-1:0]            count;
  reg                    sel_high;
  reg                    carrier_clk;
  reg                    carrier_seen_low;
  reg                    emitting;
  reg                    first_tick;

  wire tick;
  wire cmp_hit;
  wire [W-1:0] cmp_val;

  // ************************************************************
  // Count clock
  // ************************************************************
  cpg_tick_gen #(
    .PRE_W (PRE_W)
  ) u_tick (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .run_i  (carrier_timer_enable),
    .sel_i  (count_clock_select),
    .tick_o (tick)
  );

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  reg irq_s1;
  reg irq_s2;
  reg irq_s3;
  reg en_s1;
  reg en_s2;
  reg irq_seen;
  reg synced_transfer_pulse;
  reg xfer_wait;

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
      irq_s3 <= 1'b0;
      en_s1  <= 1'b0;
      en_s2  <= 1'b0;
    end else begin
      irq_s1 <= gating_timer_match_irq_i;
      irq_s2 <= irq_s1;
      irq_s3 <= irq_s2;
      en_s1  <= gating_timer_enable_i;
      en_s2  <= en_s1;
    end
  end

  // Rising edge held until the next count clock, since the irq may be shorter
  // than a count clock period
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_seen              <= 1'b0;
      synced_transfer_pulse <= 1'b0;
      xfer_wait             <= 1'b0;
    end else begin
      if (irq_s2 && !irq_s3) begin
        irq_seen <= 1'b1;
      end else if (tick) begin
        irq_seen <= 1'b0;
      end
      if (tick) begin
        synced_transfer_pulse <= irq_seen;
        xfer_wait             <= synced_transfer_pulse;
      end
    end
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_width_compare    <= `CPG_ONE;
      high_width_latch     <= `CPG_ONE;
      carrier_timer_enable <= 1'b0;
      count_clock_select   <= {`CPG_CKS_W{1'b0}};
      carrier_gate_buffer  <= 1'b0;
      remote_output_enable <= 1'b0;
    end else if (wr_i) begin
      case (addr_i)
        `CPG_REG_LOW: begin
          low_width_compare <= wdata_i;
        end
        `CPG_REG_HIGH: begin
          high_width_latch <= wdata_i;
        end
        `CPG_REG_MODE: begin
          carrier_timer_enable <= wdata_i[`CPG_MODE_EN_BIT];
          count_clock_select   <= wdata_i[`CPG_CKS_W-1:0];
        end
        `CPG_REG_CTRL: begin
          carrier_gate_buffer  <= wdata_i[`CPG_CTRL_GATEB];
          remote_output_enable <= wdata_i[`CPG_CTRL_REMOTE];
        end
        default: begin
          carrier_gate_buffer <= carrier_gate_buffer;
        end
      endcase
    end
  end

  // ************************************************************
  // High compare reload
  // ************************************************************
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      high_width_compare <= `CPG_ONE;
      high_pending       <= 1'b0;
      load_age           <= 2'h0;
    end else if (wr_i && addr_i == `CPG_REG_HIGH) begin
      high_pending <= 1'b1;
      load_age     <= 2'h0;
      if (!carrier_timer_enable) begin
        high_width_compare <= wdata_i;
      end
    end else if (!carrier_timer_enable) begin
      high_pending <= 1'b0;
      load_age     <= `CPG_LOAD_CLKS;
    end else if (tick) begin
      if (load_age != `CPG_LOAD_CLKS) begin
        load_age <= load_age + 2'h1;
      end
      // Transfer only on the old high match, once the value has aged
      if (high_pending && sel_high && cmp_hit && load_age == `CPG_LOAD_CLKS) begin
        high_width_compare <= high_width_latch;
        high_pending       <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Counter and carrier clock
  // ************************************************************
  assign cmp_val = sel_high ? high_width_compare : low_width_compare;
  assign cmp_hit = (count == cmp_val);

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count               <= `CPG_ZERO;
      sel_high            <= 1'b0;
      carrier_clk         <= 1'b0;
      carrier_match_irq_o <= 1'b0;
      first_tick          <= 1'b1;
    end else if (!carrier_timer_enable) begin
      count               <= `CPG_ZERO;
      sel_high            <= 1'b0;
      carrier_clk         <= 1'b0;
      carrier_match_irq_o <= 1'b0;
      first_tick          <= 1'b1;
    end else begin
      carrier_match_irq_o <= 1'b0;
      if (tick) begin
        if (first_tick) begin
          // Start masks one count clock; carrier stays inactive
          first_tick <= 1'b0;
        end else if (cmp_hit) begin
          carrier_match_irq_o <= 1'b1;
          carrier_clk         <= ~carrier_clk;
          count               <= `CPG_ZERO;
          sel_high            <= ~sel_high;
        end else begin
          count <= count + `CPG_ONE;
        end
      end
    end
  end

  // Stopped flag for both enables low; not used, the counter stops on the block enable alone
  wire stopped;
  assign stopped = !carrier_timer_enable && !en_s2;

  // ************************************************************
  // Gate transfer
  // ************************************************************
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      carrier_gate_active <= 1'b0;
    end else if (tick && xfer_wait) begin
      carrier_gate_active <= carrier_gate_buffer;
    end
  end

  // ************************************************************
  // Output pin
  // ************************************************************
  wire carrier_rise;
  assign carrier_rise = tick && !first_tick && cmp_hit && !carrier_clk;

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      emitting          <= 1'b0;
      carrier_seen_low  <= 1'b0;
      carrier_out_pin_o <= 1'b0;
    end else begin
      carrier_seen_low <= 1'b0;
      if (!carrier_timer_enable || !remote_output_enable) begin
        emitting <= 1'b0;
      end else if (carrier_rise) begin
        // Only a fresh rising edge opens the gate, never mid-pulse
        emitting <= carrier_gate_active;
      end else if (!carrier_gate_active && !carrier_clk) begin
        emitting <= 1'b0;
      end
      if (!remote_output_enable) begin
        carrier_out_pin_o <= carrier_gate_buffer;
      end else if (!carrier_timer_enable) begin
        carrier_out_pin_o <= 1'b0;
      end else if (carrier_rise) begin
        carrier_out_pin_o <= carrier_gate_active;
      end else if (tick && !first_tick && cmp_hit) begin
        carrier_out_pin_o <= 1'b0;
      end else if (!emitting) begin
        carrier_out_pin_o <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Read back
  // ************************************************************
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= `CPG_ZERO;
    end else if (rd_i) begin
      case (addr_i)
        `CPG_REG_LOW:  rdata_o <= low_width_compare;
        `CPG_REG_HIGH: rdata_o <= high_width_compare;
        `CPG_REG_MODE: rdata_o <= {carrier_timer_enable, {(W-1-`CPG_CKS_W){1'b0}},
                                   count_clock_select};
        `CPG_REG_CTRL: rdata_o <= {{(W-3){1'b0}}, carrier_gate_active,
                                   remote_output_enable, carrier_gate_buffer};
        `CPG_REG_STAT: rdata_o <= count;
        default:       rdata_o <= `CPG_ZERO;
      endcase
    end else begin
      rdata_o <= `CPG_ZERO;
    end
  end
endmodule

// ===== cpg_carrier_monitor.sv
// Port checker for the carrier pulse generator
module cpg_carrier_monitor (
  input wire logic       mclk_i,              // Clock
  input wire logic       nrst_i,              // Reset
  input wire logic [3:0] addr_i,              // Address
  input wire logic [7:0] wdata_i,             // Write data
  input wire logic       wr_i,                // Write
  input wire logic       rd_i,                // Read
  input wire logic [7:0] rdata_o,             // Read data
  input wire logic       carrier_match_irq_o, // Match
  input wire logic       carrier_out_pin_o    // Pin
);
  // ****************
  // Shadow registers
  // ****************
  logic en;
  logic rem;
  logic gb;
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      en  <= 1'b0;
      rem <= 1'b0;
      gb  <= 1'b0;
    end else if (wr_i && addr_i == 4'h2) begin
      en <= wdata_i[7];
    end else if (wr_i && addr_i == 4'h3) begin
      rem <= wdata_i[1];
      gb  <= wdata_i[0];
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  property p_irq_one;
    carrier_match_irq_o |=> !carrier_match_irq_o;
  endproperty
  a_irq_one: assert property (p_irq_one)
    else $error("match pulse too long");
  property p_stop;
    !en && !$past(en) |-> !carrier_match_irq_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("match while stopped");
  property p_start;
    $rose(en) |-> !carrier_match_irq_o [*2];
  endproperty
  a_start: assert property (p_start)
    else $error("match too early");
  property p_rem0;
    !rem && $stable({rem, gb}) && $past({rem, gb}, 2) == {rem, gb} |-> carrier_out_pin_o == gb;
  endproperty
  a_rem0: assert property (p_rem0)
    else $error("static pin level");
  property p_dis;
    rem && $past(rem) && !(en || $past(en) || $past(en, 2)) |-> !carrier_out_pin_o;
  endproperty
  a_dis: assert property (p_dis)
    else $error("pin high while stopped");
  property p_rise;
    rem && $past(rem) && en && $past(en) && $rose(carrier_out_pin_o)
      |-> carrier_match_irq_o || $past(carrier_match_irq_o);
  endproperty
  a_rise: assert property (p_rise)
    else $error("pin rose off a carrier edge");
  property p_fall;
    rem && $past(rem) && en && $past(en) && $fell(carrier_out_pin_o)
      |-> carrier_match_irq_o || $past(carrier_match_irq_o);
  endproperty
  a_fall: assert property (p_fall)
    else $error("pulse cut short");
  property p_rdata;
    !$past(rd_i) |-> rdata_o == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data outside its cycle");
endmodule
bind cpg_carrier cpg_carrier_monitor u_cpg_carrier_monitor (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .carrier_match_irq_o(carrier_match_irq_o), .carrier_out_pin_o(carrier_out_pin_o));

// ===== cpg_carrier_tb.sv
// Testbench for the carrier pulse generator
module cpg_carrier_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, nrst, wr, rd, run, g_en, g_irq, irq, pin;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, got;
  int         fails, n_compared, cyc;
  int         st[$];
  logic [7:0] lo_v [2] = '{8'h03, 8'h04};
  logic [7:0] hi_v [2] = '{8'h05, 8'h04};
  cpg_carrier u_cpg_carrier (.mclk_i(mclk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .gating_timer_match_irq_i(g_irq),
    .gating_timer_enable_i(g_en), .carrier_match_irq_o(irq), .carrier_out_pin_o(pin));
  cpg_gating_model u_cpg_gating_model (.mclk_i(mclk), .nrst_i(nrst), .run_i(run),
    .period_i(8'h28), .enable_o(g_en), .match_o(g_irq));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) st.push_back(cyc);
  end
  // ****************
  // Bus and checks
  // ****************
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    check(rdata, e);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wait_for(input int n);
    int k;
    for (k = 0; st.size() < n && k < 2000; k++) @(posedge mclk);
    if (k == 2000) begin
      fails++;
      close_out();
    end
  endtask
  // Restart forces the high compare to be rewritten each time
  task automatic start(input logic [7:0] lo, input logic [7:0] hi);
    wreg(4'h2, 8'h00);
    wreg(4'h0, lo);
    wreg(4'h1, hi);
    wreg(4'h3, 8'h03);
    st.delete();
    wreg(4'h2, 8'h80);
  endtask
  task automatic high_width(output logic [7:0] w);
    int k;
    w = 8'h00;
    for (k = 0; pin === 1'b1 && k < 600; k++) @(posedge mclk);
    for (k = k; pin !== 1'b1 && k < 600; k++) @(posedge mclk);
    for (k = k; pin === 1'b1 && k < 600; k++) begin
      @(posedge mclk);
      w++;
    end
  endtask
  initial begin
    nrst = 1'b0; wr = 1'b0; rd = 1'b0; run = 1'b0; addr = 4'h0; wdata = 8'h00;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) rchk(i[3:0], (i < 2) ? 8'h01 : 8'h00);
    for (int i = 0; i < 3; i++) begin
      wreg(4'h3, {7'h00, i[0]});
      repeat (3) @(posedge mclk);
      check({7'h00, pin}, {7'h00, i[0]});
    end
    $display("reset and static output done");
    run <= 1'b1;
    foreach (lo_v[j]) begin
      start(lo_v[j], hi_v[j]);
      wait_for(5);
      for (int i = 0; i < 4; i++) check(8'(st[i+1] - st[i]), (i[0] ? lo_v[j] : hi_v[j]) + 8'h01);
      repeat (100) @(posedge mclk);
      rchk(4'h3, 8'h07);
      high_width(got);
      check(got, hi_v[j] + 8'h01);
    end
    $display("carrier periods done");
    // A long old high width leaves the new value at least three count clocks to age
    start(8'h03, 8'h0a);
    wait_for(1);
    wreg(4'h1, 8'h07);
    rchk(4'h1, 8'h0a);
    wait_for(4);
    check(8'(st[1] - st[0]), 8'h0b);
    check(8'(st[2] - st[1]), 8'h04);
    check(8'(st[3] - st[2]), 8'h08);
    rchk(4'h1, 8'h07);
    $display("high compare reload done");
    wreg(4'h3, 8'h02);
    repeat (100) @(posedge mclk);
    rchk(4'h3, 8'h02);
    got = 8'h00;
    repeat (50) @(posedge mclk) got = got | {7'h00, pin};
    check(got, 8'h00);
    $display("gate off done");
    wreg(4'h2, 8'h00);
    run <= 1'b0;
    repeat (4) @(posedge mclk);
    st.delete();
    repeat (30) @(posedge mclk);
    check(8'(st.size()), 8'h00);
    rchk(4'h4, 8'h00);
    check({7'h00, pin}, 8'h00);
    $display("stop done");
    close_out();
  end
endmodule

// ===== cpg_consts.vh
// Constants for the carrier pulse generator
`ifndef CPG_CONSTS_VH
`define CPG_CONSTS_VH
`define CPG_W            8
`define CPG_ZERO         8'h00
`define CPG_ONE          8'h01
`define CPG_CKS_W        3
`define CPG_PRE_W        8
`define CPG_LOAD_CLKS    2'h3
`define CPG_ADDR_W       4
`define CPG_REG_LOW      4'h0
`define CPG_REG_HIGH     4'h1
`define CPG_REG_MODE     4'h2
`define CPG_REG_CTRL     4'h3
`define CPG_REG_STAT     4'h4
`define CPG_MODE_EN_BIT  7
`define CPG_CTRL_GATEB   0
`define CPG_CTRL_REMOTE  1
`define CPG_CTRL_ACTIVE  2
`endif

// ===== cpg_gating_model.sv
// Model of the gating timer that paces the carrier gate
module cpg_gating_model (
  input  wire logic       mclk_i,     // Clock
  input  wire logic       nrst_i,     // Reset
  input  wire logic       run_i,      // Counting enable
  input  wire logic [7:0] period_i,   // Match count; matches are period_i+1 cycles apart
  output logic            enable_o,   // Running flag
  output logic            match_o     // Match pulse
);
  logic [7:0] cnt;
  assign enable_o = run_i;
  // Pulse is one clock long, far slower than the carrier count clock
  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt     <= 8'h00;
      match_o <= 1'b0;
    end else begin
      match_o <= run_i && cnt == period_i;
      cnt     <= (!run_i || cnt == period_i) ? 8'h00 : cnt + 8'h01;
    end
  end
endmodule

// ===== cpg_tick_gen.v
// Count clock enable generator: divides mclk by two to the power of the selection
`include "cpg_consts.vh"
module cpg_tick_gen #(
  parameter PRE_W = `CPG_PRE_W
) (
  input  wire                  mclk_i,   // System clock
  input  wire                  nrst_i,   // Async reset, active low
  input  wire                  run_i,    // Prescaler runs while high
  input  wire [`CPG_CKS_W-1:0] sel_i,    // Count clock selection
  output reg                   tick_o    // One-cycle count clock pulse
);
  reg  [PRE_W-1:0] pre;
  wire [PRE_W-1:0] mask;
  wire [PRE_W:0]   ones;

  assign ones = ({{PRE_W{1'b0}}, 1'b1} << sel_i);
  assign mask = ones[PRE_W-1:0] - {{(PRE_W-1){1'b0}}, 1'b1};

  always @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre    <= {PRE_W{1'b0}};
      tick_o <= 1'b0;
    end else if (!run_i) begin
      pre    <= {PRE_W{1'b0}};
      tick_o <= 1'b0;
    end else begin
      pre    <= pre + {{(PRE_W-1){1'b0}}, 1'b1};
      tick_o <= ((pre & mask) == mask);
    end
  end
endmodule
